// *** csp_defines.vh ***
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH
// ==================================================
// slave bytes and commands
`define CSP_SLAVE_WR       8'h12
`define CSP_SLAVE_RD       8'h13
`define CSP_CMD_MODE       8'h12
`define CSP_CMD_STATUS     8'h13
`define CSP_CMD_CURRENT    8'h14
`define CSP_CMD_VOLTAGE    8'h15
`define CSP_CMD_INLIMIT    8'h3f
// ==================================================
// reset values
`define CSP_RST_WORD       16'h0000
`define CSP_RST_BYTE       8'h00
// ==================================================
// timing
`define CSP_CLK_MHZ        250
`define CSP_ALERT_MS_MIN   6
`define CSP_ALERT_MS_MAX   10
`define CSP_TIMEOUT_MS_MIN 25
`define CSP_TIMEOUT_MS_MAX 35
`define CSP_CYC_PER_MS     (`CSP_CLK_MHZ * 1000)
// ==================================================
// protocol states
`define CSP_ST_IDLE        3'd0
`define CSP_ST_ADDR        3'd1
`define CSP_ST_CMD         3'd2
`define CSP_ST_WDATA       3'd3
`define CSP_ST_RDATA       3'd4
`define CSP_ST_ACK         3'd5
`define CSP_ST_HACK        3'd6
`endif

// *** csp_smbus_slave.v ***
`include "csp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module csp_smbus_slave #(
	parameter [31:0] ALERT_CYCLES   = `CSP_ALERT_MS_MIN * `CSP_CYC_PER_MS,
	parameter [31:0] TIMEOUT_CYCLES = `CSP_TIMEOUT_MS_MIN * `CSP_CYC_PER_MS
) (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_scl,
	input  wire        i_sda,
	output reg         o_sda,
	output reg         o_sda_oe_n,
	input  wire [15:0] i_condition_flags,
	output reg  [15:0] o_mode_control,
	output reg  [15:0] o_charge_current,
	output reg  [15:0] o_charge_voltage,
	output reg  [15:0] o_adapter_limit,
	output reg         o_alert
);
	// ==================================================
	// helpers
	function cmd_ok;
		input [7:0] c;
		begin
			cmd_ok = (c == `CSP_CMD_MODE) || (c == `CSP_CMD_STATUS) || (c == `CSP_CMD_CURRENT) ||
				(c == `CSP_CMD_VOLTAGE) || (c == `CSP_CMD_INLIMIT);
		end
	endfunction
	function cmd_wr;
		input [7:0] c;
		begin
			cmd_wr = cmd_ok(c) && (c != `CSP_CMD_STATUS);
		end
	endfunction

	// ==================================================
	// input synchronisers
	reg [1:0] scl_s;
	reg [1:0] sda_s;
	reg       scl_d;
	reg       sda_d;
	reg [15:0] flags_s1;
	reg [15:0] flags_s2;
	reg [15:0] flags_d;
	reg [15:0] flags_st;
	always @(posedge i_clk) begin
		scl_s    <= {scl_s[0], i_scl};
		sda_s    <= {sda_s[0], i_sda};
		flags_s1 <= i_condition_flags;
		flags_s2 <= flags_s1;
		if (i_rst) begin
			scl_s    <= 2'b11;
			sda_s    <= 2'b11;
		end
	end
	// ==================================================
	// status word taken only when two samples agree
	// reset loads the live word: no false alert
	always @(posedge i_clk) begin
		if (i_rst)
			flags_st <= flags_s2;
		else if (flags_s2 == flags_s1)
			flags_st <= flags_s2;
	end
	wire scl = scl_s[1];
	wire sda = sda_s[1];
	always @(posedge i_clk) begin
		if (i_rst) begin
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
			flags_d <= flags_st;
		end else begin
			scl_d   <= scl;
			sda_d   <= sda;
			flags_d <= flags_st;
		end
	end
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = scl & scl_d & sda_d & ~sda;
	wire stop_c   = scl & scl_d & ~sda_d & sda;

	// ==================================================
	// bus release timeout
	reg [31:0] low_cnt;
	reg        tmo;
	always @(posedge i_clk) begin
		if (i_rst || sda) begin
			low_cnt <= 32'h0000_0000;
			tmo     <= 1'b0;
		end else if (low_cnt == TIMEOUT_CYCLES) begin
			tmo <= 1'b1;
		end else begin
			low_cnt <= low_cnt + 32'h0000_0001;
			tmo     <= 1'b0;
		end
	end

	// ==================================================
	// protocol engine, slave only: never frames the bus
	reg [2:0]  state;
	reg [2:0]  after_ack;
	reg [3:0]  bitn;
	reg [7:0]  shreg;
	reg [7:0]  cmd;
	reg        cmd_valid;
	reg        byte_hi;
	reg [7:0]  lo_byte;
	reg        ack_drive;
	reg        commit;
	reg [15:0] rd_word;
	always @* begin
		case (cmd)
			`CSP_CMD_MODE:    rd_word = o_mode_control;
			`CSP_CMD_STATUS:  rd_word = flags_st;
			`CSP_CMD_CURRENT: rd_word = o_charge_current;
			`CSP_CMD_VOLTAGE: rd_word = o_charge_voltage;
			`CSP_CMD_INLIMIT: rd_word = o_adapter_limit;
			default:          rd_word = `CSP_RST_WORD;
		endcase
	end
	wire [7:0] rd_byte = byte_hi ? rd_word[15:8] : rd_word[7:0];

	always @(posedge i_clk) begin
		if (i_rst) begin
			state     <= `CSP_ST_IDLE;
			after_ack <= `CSP_ST_IDLE;
			bitn      <= 4'd0;
			shreg     <= `CSP_RST_BYTE;
			cmd       <= `CSP_RST_BYTE;
			cmd_valid <= 1'b0;
			byte_hi   <= 1'b0;
			lo_byte   <= `CSP_RST_BYTE;
			ack_drive <= 1'b0;
			commit    <= 1'b0;
			o_sda     <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (tmo || stop_c) begin
			state      <= `CSP_ST_IDLE;
			o_sda_oe_n <= 1'b1;
			commit     <= 1'b0;
		end else if (start_c) begin
			state      <= `CSP_ST_ADDR;
			bitn       <= 4'd0;
			byte_hi    <= 1'b0;
			o_sda_oe_n <= 1'b1;
			commit     <= 1'b0;
		end else begin
			case (state)
				`CSP_ST_IDLE: begin
					o_sda_oe_n <= 1'b1;
				end
				`CSP_ST_ADDR, `CSP_ST_CMD, `CSP_ST_WDATA: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda};
						bitn  <= bitn + 4'd1;
					end
					if (scl_fall && bitn == 4'd8) begin
						bitn <= 4'd0;
						ack_drive <= 1'b0;
						after_ack <= `CSP_ST_IDLE;
						if (state == `CSP_ST_ADDR) begin
							if (shreg == `CSP_SLAVE_WR) begin
								ack_drive <= 1'b1;
								after_ack <= `CSP_ST_CMD;
							end else if (shreg == `CSP_SLAVE_RD && cmd_valid) begin
								ack_drive <= 1'b1;
								after_ack <= `CSP_ST_RDATA;
							end
						end else if (state == `CSP_ST_CMD) begin
							if (cmd_ok(shreg)) begin
								cmd       <= shreg;
								cmd_valid <= 1'b1;
								ack_drive <= 1'b1;
								after_ack <= `CSP_ST_WDATA;
								byte_hi   <= 1'b0;
							end else begin
								cmd_valid <= 1'b0;
							end
						end else begin
							ack_drive <= 1'b1;
							if (!byte_hi) begin
								lo_byte   <= shreg;
								byte_hi   <= 1'b1;
								after_ack <= `CSP_ST_WDATA;
							end else begin
								commit    <= 1'b1;
							end
						end
						state <= `CSP_ST_ACK;
					end
				end
				`CSP_ST_ACK: begin
					// nack: line stays released, then idle
					o_sda      <= 1'b0;
					o_sda_oe_n <= ~ack_drive;
					if (scl_fall) begin
						o_sda_oe_n <= 1'b1;
						state      <= after_ack;
						commit     <= 1'b0;
						if (after_ack == `CSP_ST_RDATA)
							o_sda_oe_n <= rd_byte[7];
						shreg <= rd_byte;
					end
				end
				`CSP_ST_RDATA: begin
					if (scl_fall) begin
						bitn <= bitn + 4'd1;
						if (bitn == 4'd7) begin
							o_sda_oe_n <= 1'b1;
							state      <= `CSP_ST_HACK;
						end else begin
							o_sda_oe_n <= shreg[6];
							shreg      <= {shreg[6:0], 1'b0};
						end
					end
				end
				`CSP_ST_HACK: begin
					if (scl_rise) begin
						bitn    <= 4'd0;
						byte_hi <= 1'b1;
						state   <= sda ? `CSP_ST_IDLE : `CSP_ST_ACK;
						ack_drive <= 1'b0;
						after_ack <= `CSP_ST_RDATA;
						if (byte_hi)
							state <= `CSP_ST_IDLE;
					end
				end
				default: state <= `CSP_ST_IDLE;
			endcase
		end
	end

	// ==================================================
	// register commit at end of final ack
	wire do_commit = commit && state == `CSP_ST_ACK && scl_fall &&
		!start_c && !stop_c && !tmo;
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_mode_control   <= `CSP_RST_WORD;
			o_charge_current <= `CSP_RST_WORD;
			o_charge_voltage <= `CSP_RST_WORD;
			o_adapter_limit  <= `CSP_RST_WORD;
		end else if (do_commit && cmd_wr(cmd)) begin
			case (cmd)
				`CSP_CMD_MODE:    o_mode_control   <= {shreg, lo_byte};
				`CSP_CMD_CURRENT: o_charge_current <= {shreg, lo_byte};
				`CSP_CMD_VOLTAGE: o_charge_voltage <= {shreg, lo_byte};
				`CSP_CMD_INLIMIT: o_adapter_limit  <= {shreg, lo_byte};
				default: ;
			endcase
		end
	end

	// ==================================================
	// delayed alert on status change
	reg [31:0] alm_cnt;
	reg        alm_run;
	always @(posedge i_clk) begin
		if (i_rst) begin
			alm_cnt <= 32'h0000_0000;
			alm_run <= 1'b0;
			o_alert <= 1'b0;
		end else begin
			if (flags_st != flags_d) begin
				alm_run <= 1'b1;
				alm_cnt <= 32'h0000_0000;
				o_alert <= 1'b0;
			end else if (alm_run) begin
				if (alm_cnt == ALERT_CYCLES) begin
					o_alert <= 1'b1;
					alm_run <= 1'b0;
				end else begin
					alm_cnt <= alm_cnt + 32'h0000_0001;
				end
			end
		end
	end
endmodule // csp_smbus_slave
`default_nettype wire

// *** csp_smbus_slave_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module csp_smbus_slave_chk #(
	parameter [31:0] ALERT_CYCLES   = 200,
	parameter [31:0] TIMEOUT_CYCLES = 300
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_scl,
	input wire logic        i_sda,
	input wire logic        o_sda,
	input wire logic        o_sda_oe_n,
	input wire logic [15:0] i_condition_flags,
	input wire logic [15:0] o_mode_control,
	input wire logic [15:0] o_charge_current,
	input wire logic [15:0] o_charge_voltage,
	input wire logic [15:0] o_adapter_limit,
	input wire logic        o_alert
);
// ====
// cycles since status change, cycles of sda low
logic [31:0] acnt;
logic [31:0] lcnt;
always @(posedge i_clk) begin
	if (i_rst)
		acnt <= '0;
	else if (i_condition_flags != $past(i_condition_flags))
		acnt <= 32'h0000_0001;
	else if (acnt != '0 && acnt < ALERT_CYCLES + 20)
		acnt <= acnt + 1;
	lcnt <= (i_rst || i_sda) ? '0 : lcnt + 1;
end
// ====
// properties
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
a_sda_only_low: assert property (o_sda == 1'b0) else $error("sda value not low");
a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl) else $error("drive with scl high");
a_ack_hold: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*8]) else $error("drive too short");
a_commit_scl_low: assert property (
	$changed({o_mode_control, o_charge_current, o_charge_voltage, o_adapter_limit}) |-> !i_scl)
	else $error("reg change scl high");
a_alert_early: assert property ($rose(o_alert) |-> acnt >= ALERT_CYCLES - 2) else $error("alert early");
a_alert_late: assert property (acnt == ALERT_CYCLES + 12 |-> o_alert) else $error("alert late");
a_alert_drop: assert property ($fell(o_alert) |-> acnt inside {[1:6]}) else $error("alert drop");
a_timeout_release: assert property (lcnt == TIMEOUT_CYCLES + 8 |-> o_sda_oe_n) else $error("no release");
c_alert: cover property ($rose(o_alert));
c_drive: cover property ($fell(o_sda_oe_n));
c_commit: cover property ($changed(o_adapter_limit));
endmodule // csp_smbus_slave_chk
bind csp_smbus_slave csp_smbus_slave_chk #(.ALERT_CYCLES(ALERT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.i_clk, .i_rst, .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .i_condition_flags, .o_mode_control,
	.o_charge_current, .o_charge_voltage, .o_adapter_limit, .o_alert);
`default_nettype wire

// *** csp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// smbus host master, 48 ns clock
module csp_host_model (
	output var logic o_scl,
	output var logic o_sda,
	input wire logic i_sda
);
initial {o_scl, o_sda} = 2'b11;
task bitx(input logic b, output logic r);
	o_sda = b;
	#12 o_scl = 1;
	#12 r = i_sda;
	#12 o_scl = 0;
	#12;
endtask
task start;
	o_sda = 1;
	#12 o_scl = 1;
	#12 o_sda = 0;
	#12 o_scl = 0;
	#12;
endtask
task stop;
	o_sda = 0;
	#12 o_scl = 1;
	#12 o_sda = 1;
	#12;
endtask
task wbyte(input logic [7:0] d, output logic a);
	logic r;
	for (int i = 7; i >= 0; i--) bitx(d[i], r);
	bitx(1, r);
	a = !r;
endtask
task rbyte(input logic ha, output logic [7:0] d);
	logic r;
	for (int i = 7; i >= 0; i--) bitx(1, d[i]);
	bitx(!ha, r);
endtask
endmodule // csp_host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
localparam int AC = 200;
localparam int TC = 300;
localparam logic [7:0] WA = 8'h12;
typedef struct {logic [7:0] c; logic [15:0] d;} csp_row_t;
csp_row_t    rows [5] = '{'{8'h12, 16'h1234}, '{8'h14, 16'h0a5c}, '{8'h15, 16'hffee},
	'{8'h3f, 16'h0001}, '{8'h13, 16'h7777}};
logic        i_clk = 0;
logic        i_rst = 1;
logic        scl, h_sda, sda_w, oe_n, o_sda, o_alert, ak;
logic [15:0] flags = 16'h8421;
logic [15:0] rg [4];
logic [15:0] rd;
int          err_total = 0;
int          checks_done = 0;
always #2 i_clk = ~i_clk;
assign sda_w = h_sda & (oe_n | o_sda);
csp_host_model u_csp_host_model (.o_scl(scl), .o_sda(h_sda), .i_sda(sda_w));
csp_smbus_slave #(.ALERT_CYCLES(AC), .TIMEOUT_CYCLES(TC)) u_csp_smbus_slave (.i_clk, .i_rst, .i_scl(scl),
	.i_sda(sda_w), .o_sda, .o_sda_oe_n(oe_n), .i_condition_flags(flags), .o_mode_control(rg[0]),
	.o_charge_current(rg[1]), .o_charge_voltage(rg[2]), .o_adapter_limit(rg[3]), .o_alert);
// ====
// tasks
task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
	checks_done++;
	if (g !== e) begin
		err_total++;
		$display("[FAIL] %s expected %h seen %h", n, e, g);
	end
endtask
task wr(input logic [7:0] c, input logic [15:0] d, input bit p);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(WA, ak);
	u_csp_host_model.wbyte(c, ak);
	u_csp_host_model.wbyte(d[7:0], ak);
	u_csp_host_model.wbyte(d[15:8], ak);
	if (p) u_csp_host_model.stop();
endtask
task rdw(input logic [7:0] c);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(WA, ak);
	u_csp_host_model.wbyte(c, ak);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(8'h13, ak);
	u_csp_host_model.rbyte(1, rd[7:0]);
	u_csp_host_model.rbyte(0, rd[15:8]);
	u_csp_host_model.stop();
endtask
task conclude;
	$display("checks %0d errors %0d", checks_done, err_total);
	if (err_total == 0 && checks_done > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
// ====
// sequence
initial begin
	repeat (12) @(posedge i_clk);
	i_rst <= 0;
	repeat (8) @(posedge i_clk);
	foreach (rows[i]) begin
		wr(rows[i].c, rows[i].d, 1);
		cmp("write ack", 1, ak);
		rdw(rows[i].c);
		cmp("read word", rows[i].c == 8'h13 ? flags : rows[i].d, rd);
	end
	for (int i = 0; i < 4; i++) cmp("reg port", rows[i].d, rg[i]);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(8'h24, ak);
	cmp("foreign ack", 0, ak);
	u_csp_host_model.wbyte(WA, ak);
	cmp("idle ack", 0, ak);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(WA, ak);
	u_csp_host_model.wbyte(8'h16, ak);
	cmp("reserved ack", 0, ak);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(8'h13, ak);
	cmp("read addr ack", 0, ak);
	wr(8'h14, 16'hbeef, 0);
	u_csp_host_model.start();
	u_csp_host_model.wbyte(WA, ak);
	u_csp_host_model.wbyte(8'h15, ak);
	u_csp_host_model.wbyte(8'h99, ak);
	wr(8'h3f, 16'h4242, 1);
	cmp("chained", 16'hbeef, rg[1]);
	cmp("aborted", 16'hffee, rg[2]);
	cmp("chained", 16'h4242, rg[3]);
	u_csp_host_model.start();
	for (int i = 7; i >= 0; i--) u_csp_host_model.bitx(WA[i], ak);
	repeat (TC + 40) @(posedge i_clk);
	cmp("bus release", 1, oe_n);
	cmp("sda value", 0, o_sda);
	u_csp_host_model.stop();
	@(posedge i_clk);
	flags <= 16'h8420;
	repeat (AC - 10) @(posedge i_clk);
	cmp("alert early", 0, o_alert);
	repeat (130) @(posedge i_clk);
	cmp("alert", 1, o_alert);
	i_rst <= 1;
	repeat (4) @(posedge i_clk);
	i_rst <= 0;
	@(posedge i_clk);
	cmp("reset reg", 16'h0000, rg[3]);
	cmp("reset alert", 0, o_alert);
	conclude();
end
initial begin
	#200000;
	err_total++;
	conclude();
end
endmodule // testbench
`default_nettype wire
